// file: logic/ifhdp_pkg.sv
// Constants, field positions and types for the image FIFO host/DMA port.
// Assumes one 50 MHz clock with a synchronous active-high reset.
package ifhdp_pkg;

	localparam int unsigned FIFO_DEPTH = 2048;
	localparam int unsigned CNT_W = 12;
	localparam int unsigned PTR_W = 11;

	// Indirect register offsets
	localparam logic [2:0] OFF_FIFO = 3'h0;
	localparam logic [2:0] OFF_CTRL = 3'h1;
	localparam logic [2:0] OFF_MASK = 3'h2;
	localparam logic [2:0] OFF_ACK = 3'h3;
	localparam logic [2:0] OFF_THR_LO = 3'h4;
	localparam logic [2:0] OFF_THR_HI = 3'h5;
	localparam logic [2:0] OFF_CNT_LO = 3'h6;
	localparam logic [2:0] OFF_CNT_HI = 3'h7;

	// transfer_control fields
	localparam int unsigned CTRL_IRQ_POL = 5;
	localparam int unsigned CTRL_DRQ_POL = 4;
	localparam int unsigned CTRL_BURST_LENGTH_SELECT_HI = 3;
	localparam int unsigned CTRL_BURST_LENGTH_SELECT_LO = 2;
	localparam int unsigned CTRL_FLUSH = 0;

	localparam logic [1:0] BURST_LENGTH_SELECT_OFF = 2'h0;
	localparam logic [1:0] BURST_LENGTH_SELECT_8 = 2'h1;
	localparam logic [1:0] BURST_LENGTH_SELECT_16 = 2'h2;
	localparam logic [5:0] BURST_LEN_8 = 6'h08;
	localparam logic [5:0] BURST_LEN_16 = 6'h10;
	localparam logic [5:0] BURST_LEN_32 = 6'h20;

	// fifo_level_threshold fields
	localparam int unsigned THR_TH_LO = 4;
	localparam int unsigned THR_TH_HI_IN_HI = 2;
	localparam int unsigned THR_NE = 0;
	localparam int unsigned TH_W = 7;
	localparam int unsigned TH_SHIFT = 4;
	localparam logic [CNT_W-1:0] THR_ONE = 12'h001;

	// host_status_byte bit positions
	localparam int unsigned ST_IRQ = 7;
	localparam int unsigned ST_EOF = 5;
	localparam int unsigned ST_SOF = 4;
	localparam int unsigned ST_MCI = 3;
	localparam int unsigned ST_FIFO_ERROR_FLAG = 2;
	localparam int unsigned ST_FIFO_LEVEL_REACHED = 1;
	localparam int unsigned ST_RDY = 0;
	localparam int unsigned MASK_W = 6;

	typedef enum logic [0:0] {
		IFHDP_DMA_WAIT,
		IFHDP_DMA_BURST
	} ifhdp_dma_e;

endpackage : ifhdp_pkg

// file: logic/ifhdp_store.sv
// Flip-flop image byte FIFO with count, flush, and drop-on-full.
// Ignores pops on empty itself; a flush wins over a pop.
`timescale 1ns/1ps
`default_nettype none
module ifhdp_store
	import ifhdp_pkg::*;
(
	input wire logic core_clk_i, // 50 MHz clock
	input wire logic srst_i, // Synchronous reset, high
	input wire logic flush_i, // Empty the FIFO
	input wire logic push_i, // Store a byte
	input wire logic [7:0] push_data_i, // Byte to store
	input wire logic pop_i, // Drop the oldest byte
	output logic [7:0] head_o, // Oldest byte
	output logic [ifhdp_pkg::CNT_W-1:0] count_o, // Bytes held
	output logic full_o, // No room
	output logic empty_o // Nothing held
);
	import ifhdp_pkg::*;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][7:0] mem;
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [CNT_W-1:0] cnt;
	} ifhdp_store_s;

	ifhdp_store_s s_q;
	ifhdp_store_s s_d;
	logic do_push;
	logic do_pop;

	always_comb
	begin
		s_d = s_q;
		do_pop = pop_i && !empty_o && !flush_i;
		// Data arriving with a flush is the first byte of the new frame
		do_push = push_i && (flush_i || !full_o);
		if (flush_i)
		begin
			s_d.wptr = '0;
			s_d.rptr = '0;
			s_d.cnt = '0;
		end
		if (do_pop)
		begin
			s_d.rptr = s_q.rptr + 1'b1;
		end
		if (do_push)
		begin
			s_d.mem[s_d.wptr] = push_data_i;
			s_d.wptr = s_d.wptr + 1'b1;
		end
		if (!flush_i)
		begin
			s_d.cnt = s_q.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
		end
		else if (do_push)
		begin
			s_d.cnt = THR_ONE;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			s_q.wptr <= '0;
			s_q.rptr <= '0;
			s_q.cnt <= '0;
			s_q.mem <= s_q.mem;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign head_o = s_q.mem[s_q.rptr];
	assign count_o = s_q.cnt;
	assign full_o = (s_q.cnt == CNT_W'(FIFO_DEPTH));
	assign empty_o = (s_q.cnt == '0);
endmodule : ifhdp_store
`default_nettype wire

// file: logic/ifhdp_top.sv
// Image FIFO host port: indirect registers, level flag, DMA request, IRQ.
// Register strobes, image bytes, envelope and micro-core event all come
// from logic on core_clk_i, so no input is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module ifhdp_top
	import ifhdp_pkg::*;
(
	input wire logic core_clk_i, // 50 MHz clock
	input wire logic srst_i, // Synchronous reset, high
	input wire logic reg_wr_i, // Indirect register write strobe
	input wire logic reg_rd_i, // Indirect register read strobe
	input wire logic [2:0] reg_addr_i, // Indirect register offset
	input wire logic [7:0] reg_wdata_i, // Write data
	output logic [7:0] reg_rdata_o, // Read data, valid after read
	input wire logic img_valid_i, // Image byte strobe
	input wire logic [7:0] img_data_i, // Image byte
	input wire logic vertical_envelope_i, // Output frame envelope
	input wire logic mci_event_i, // Micro-core event pulse
	output logic [7:0] host_status_byte_o, // Status byte
	output logic fifo_level_reached_o, // Count at or above threshold
	output logic irq_pin_o, // Interrupt pin, programmed polarity
	output logic dma_request_pin_o, // DMA request pin level
	output logic dma_request_pin_oe_o // DMA request pin driven
);
	import ifhdp_pkg::*;

	typedef struct packed {
		logic irq_pol;
		logic drq_pol;
		logic [1:0] burst_length_select;
		logic [MASK_W-1:0] mask;
		logic [TH_W-1:0] th;
		logic ne;
		logic [ST_EOF:ST_FIFO_ERROR_FLAG] src;
		logic vertical_envelope_prev;
		logic [7:0] last_byte;
		logic [7:0] rdata;
		logic [7:0] status;
		logic fifo_level_reached;
		logic irq_pin;
		logic drq_pin;
		logic drq_oe;
		logic drq_act;
		ifhdp_dma_e dma_st;
		logic [5:0] burst_left;
	} ifhdp_state_s;

	ifhdp_state_s s_q;
	ifhdp_state_s s_d;

	logic [7:0] head;
	logic [CNT_W-1:0] count;
	logic full;
	logic empty;
	logic flush;
	logic pop;
	logic fifo_rd;
	logic vertical_envelope_rise;
	logic vertical_envelope_fall;
	logic wr_ctrl;
	logic wr_ack;
	logic [CNT_W-1:0] thr;
	logic [ST_EOF:ST_FIFO_ERROR_FLAG] set_src;
	logic [ST_EOF:ST_FIFO_ERROR_FLAG] clr_src;
	logic [7:0] status_now;
	logic irq_now;
	logic fifo_level_reached_now;
	logic burst_done;

	function automatic logic reg_hit(input logic strobe,
		input logic [2:0] addr, input logic [2:0] off);
		reg_hit = strobe && (addr == off);
	endfunction : reg_hit

	function automatic logic [5:0] burst_len(input logic [1:0] burst_length_select);
		case (burst_length_select)
			BURST_LENGTH_SELECT_8: burst_len = BURST_LEN_8;
			BURST_LENGTH_SELECT_16: burst_len = BURST_LEN_16;
			default: burst_len = BURST_LEN_32;
		endcase
	endfunction : burst_len

	function automatic logic [CNT_W-1:0] active_thr(input logic ne,
		input logic [TH_W-1:0] th, input logic vertical_envelope);
		// Between frames the threshold drops to one so the tail drains
		if (ne || !vertical_envelope)
		begin
			active_thr = THR_ONE;
		end
		else
		begin
			active_thr = {{(CNT_W-TH_W-TH_SHIFT){1'b0}}, th,
				{TH_SHIFT{1'b0}}};
		end
	endfunction : active_thr

	ifhdp_store u_store (
		.core_clk_i (core_clk_i),
		.srst_i (srst_i),
		.flush_i (flush),
		.push_i (img_valid_i),
		.push_data_i (img_data_i),
		.pop_i (pop),
		.head_o (head),
		.count_o (count),
		.full_o (full),
		.empty_o (empty)
	);

	// Decode and events shared by the state update
	always_comb
	begin
		fifo_rd = reg_hit(reg_rd_i, reg_addr_i, OFF_FIFO);
		pop = fifo_rd && !empty;
		wr_ctrl = reg_hit(reg_wr_i, reg_addr_i, OFF_CTRL);
		wr_ack = reg_hit(reg_wr_i, reg_addr_i, OFF_ACK);
		vertical_envelope_rise = vertical_envelope_i && !s_q.vertical_envelope_prev;
		vertical_envelope_fall = !vertical_envelope_i && s_q.vertical_envelope_prev;
		flush = vertical_envelope_rise || (wr_ctrl && reg_wdata_i[CTRL_FLUSH]);
		thr = active_thr(s_q.ne, s_q.th, vertical_envelope_i);
		fifo_level_reached_now = (count >= thr);
		burst_done = (s_q.dma_st == IFHDP_DMA_BURST) && fifo_rd &&
			(s_q.burst_left == '0);
		set_src = '0;
		set_src[ST_SOF] = vertical_envelope_rise;
		set_src[ST_EOF] = vertical_envelope_fall;
		set_src[ST_MCI] = mci_event_i;
		// Leftover bytes at frame start, or a byte lost to a full FIFO while the envelope is high
		set_src[ST_FIFO_ERROR_FLAG] = (vertical_envelope_rise && !empty) ||
			(vertical_envelope_i && img_valid_i && full && !flush);
		// Image done: last burst byte taken, FIFO drained, frame over
		if (burst_done && (count <= THR_ONE) && !vertical_envelope_i)
		begin
			set_src[ST_EOF] = 1'b1;
		end
		clr_src = wr_ack ? reg_wdata_i[ST_EOF:ST_FIFO_ERROR_FLAG] : '0;
		status_now = '0;
		status_now[ST_EOF:ST_FIFO_ERROR_FLAG] = s_q.src;
		status_now[ST_FIFO_LEVEL_REACHED] = s_q.fifo_level_reached;
		status_now[ST_RDY] = 1'b1;
		irq_now = |(status_now[MASK_W-1:0] & s_q.mask);
		status_now[ST_IRQ] = irq_now;
	end

	always_comb
	begin
		s_d = s_q;
		s_d.vertical_envelope_prev = vertical_envelope_i;
		// A source raised in the cycle it is acknowledged stays raised
		s_d.src = (s_q.src & ~clr_src) | set_src;
		s_d.fifo_level_reached = fifo_level_reached_now;

		if (wr_ctrl)
		begin
			s_d.irq_pol = reg_wdata_i[CTRL_IRQ_POL];
			s_d.drq_pol = reg_wdata_i[CTRL_DRQ_POL];
			s_d.burst_length_select = reg_wdata_i[CTRL_BURST_LENGTH_SELECT_HI:CTRL_BURST_LENGTH_SELECT_LO];
		end
		if (reg_hit(reg_wr_i, reg_addr_i, OFF_MASK))
		begin
			s_d.mask = reg_wdata_i[MASK_W-1:0];
		end
		if (reg_hit(reg_wr_i, reg_addr_i, OFF_THR_LO))
		begin
			s_d.ne = reg_wdata_i[THR_NE];
			s_d.th[TH_W-THR_TH_HI_IN_HI-2:0] =
				reg_wdata_i[7:THR_TH_LO];
		end
		if (reg_hit(reg_wr_i, reg_addr_i, OFF_THR_HI))
		begin
			s_d.th[TH_W-1:TH_W-THR_TH_HI_IN_HI-1] =
				reg_wdata_i[THR_TH_HI_IN_HI:0];
		end

		if (pop)
		begin
			s_d.last_byte = head;
		end

		// Read data is captured on the strobe; no wait state ever
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				OFF_FIFO:
				begin
					// Empty reads replay the last byte; pads a short burst
					s_d.rdata = empty ? s_q.last_byte : head;
				end
				OFF_CTRL:
				begin
					s_d.rdata = {2'b00, s_q.irq_pol, s_q.drq_pol,
						s_q.burst_length_select, 2'b00};
				end
				OFF_MASK:
				begin
					s_d.rdata = {2'b00, s_q.mask};
				end
				OFF_THR_LO:
				begin
					s_d.rdata = {s_q.th[TH_W-THR_TH_HI_IN_HI-2:0],
						3'b000, s_q.ne};
				end
				OFF_THR_HI:
				begin
					s_d.rdata = {5'b00000,
						s_q.th[TH_W-1:TH_W-THR_TH_HI_IN_HI-1]};
				end
				OFF_CNT_LO:
				begin
					s_d.rdata = count[7:0];
				end
				OFF_CNT_HI:
				begin
					s_d.rdata = {4'h0, count[CNT_W-1:8]};
				end
				default:
				begin
					// Acknowledge register is write-only
					s_d.rdata = 8'h00;
				end
			endcase
		end

		// DMA request sequencing
		case (s_q.dma_st)
			IFHDP_DMA_WAIT:
			begin
				s_d.drq_act = fifo_level_reached_now;
				if (fifo_rd && s_q.drq_act)
				begin
					s_d.drq_act = 1'b0;
					s_d.dma_st = IFHDP_DMA_BURST;
					s_d.burst_left = burst_len(s_q.burst_length_select) - 6'h02;
				end
			end
			IFHDP_DMA_BURST:
			begin
				// Dummy reads of an empty FIFO count toward the burst
				s_d.drq_act = 1'b0;
				if (fifo_rd)
				begin
					if (s_q.burst_left == '0)
					begin
						s_d.dma_st = IFHDP_DMA_WAIT;
					end
					else
					begin
						s_d.burst_left = s_q.burst_left - 1'b1;
					end
				end
			end
			default:
			begin
				s_d.dma_st = IFHDP_DMA_WAIT;
			end
		endcase
		if (s_d.burst_length_select == BURST_LENGTH_SELECT_OFF)
		begin
			s_d.dma_st = IFHDP_DMA_WAIT;
			s_d.drq_act = 1'b0;
		end

		// Pin levels include polarity; a disabled request pin floats
		s_d.drq_oe = (s_d.burst_length_select != BURST_LENGTH_SELECT_OFF);
		s_d.drq_pin = s_d.drq_act ^ s_d.drq_pol;
		s_d.irq_pin = irq_now ^ s_d.irq_pol;
		s_d.status = status_now;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			s_q.irq_pol <= 1'b0;
			s_q.drq_pol <= 1'b0;
			s_q.burst_length_select <= BURST_LENGTH_SELECT_OFF;
			s_q.mask <= '0;
			s_q.th <= '0;
			s_q.ne <= 1'b0;
			s_q.src <= '0;
			s_q.vertical_envelope_prev <= 1'b0;
			s_q.last_byte <= 8'h00;
			s_q.rdata <= 8'h00;
			s_q.status <= 8'h01;
			s_q.fifo_level_reached <= 1'b0;
			s_q.irq_pin <= 1'b0;
			s_q.drq_pin <= 1'b0;
			s_q.drq_oe <= 1'b0;
			s_q.drq_act <= 1'b0;
			s_q.dma_st <= IFHDP_DMA_WAIT;
			s_q.burst_left <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o = s_q.rdata;
	assign host_status_byte_o = s_q.status;
	assign fifo_level_reached_o = s_q.fifo_level_reached;
	assign irq_pin_o = s_q.irq_pin;
	assign dma_request_pin_o = s_q.drq_pin;
	assign dma_request_pin_oe_o = s_q.drq_oe;
endmodule : ifhdp_top
`default_nettype wire

// file: testbench/ifhdp_bench.sv
// Self-checking bench for the image FIFO host port.
// Assumes the host model owns the register strobes.
`timescale 1ns/1ps
`default_nettype none
module ifhdp_bench;
	import ifhdp_pkg::*;
	logic clk, srst, wr, rd, iv, vertical_envelope, mci, dma_on, slow, pol;
	logic [2:0] addr;
	logic [7:0] wd, rdat, idat, st, v, pad;
	logic lvl, irq, dma_request_pin, oe;
	logic [5:0] len;
	logic [7:0] exp_q [$];
	int miscompares = 0;
	int comparisons = 0;
	ifhdp_top dut (.core_clk_i(clk), .srst_i(srst), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
		.img_valid_i(iv), .img_data_i(idat), .vertical_envelope_i(vertical_envelope),
		.mci_event_i(mci), .host_status_byte_o(st), .fifo_level_reached_o(lvl),
		.irq_pin_o(irq), .dma_request_pin_o(dma_request_pin), .dma_request_pin_oe_o(oe));
	ifhdp_host u_host (.clk_i(clk), .dma_on_i(dma_on), .slow_i(slow),
		.pol_i(pol), .len_i(len), .drq_i(dma_request_pin), .drq_oe_i(oe), .rdata_i(rdat),
		.wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] seen, input logic [15:0] want,
		input string what);
		comparisons++;
		if (seen !== want)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	task automatic rchk(input logic [2:0] a, input logic [7:0] want,
		input string what);
		u_host.rd(a, v);
		chk(16'(v), 16'(want), what);
	endtask : rchk
	task automatic push(input int n);
		repeat (n)
		begin
			@(negedge clk);
			iv = 1'b1;
			idat = idat + 8'h01;
			exp_q.push_back(idat);
		end
		@(negedge clk);
		iv = 1'b0;
	endtask : push
	task automatic pop(input int n);
		repeat (n)
		begin
			u_host.rd(OFF_FIFO, v);
			chk(16'(v), 16'(exp_q.pop_front()), "fifo byte");
		end
	endtask : pop
	task automatic settle;
		repeat (3) @(negedge clk);
	endtask : settle
	task automatic wait_dma(input int n);
		int t = 0;
		while (u_host.got.size() < n && t < 2000)
		begin
			@(negedge clk);
			t++;
		end
		if (t >= 2000)
		begin
			miscompares++;
			report_and_stop();
		end
		repeat (8) @(negedge clk);
	endtask : wait_dma
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		{srst, iv, vertical_envelope, mci, dma_on, slow, pol} = 7'h40;
		idat = 8'h00;
		len = 6'h08;
		repeat (5) @(negedge clk);
		srst = 1'b0;
		chk(16'(st), 16'h0001, "status reset");
		u_host.wr(OFF_CTRL, 8'hff);
		rchk(OFF_CTRL, 8'h3c, "ctrl readback");
		u_host.wr(OFF_CTRL, 8'h00);
		vertical_envelope = 1'b1;
		push(20);
		rchk(OFF_CNT_LO, 8'h14, "count lo");
		rchk(OFF_CNT_HI, 8'h00, "count hi");
		pop(3);
		u_host.wr(OFF_THR_LO, 8'h10);
		settle();
		chk(16'(lvl), 16'h0001, "level 17 of 16");
		pop(2);
		settle();
		chk(16'(lvl), 16'h0000, "level 15 of 16");
		u_host.wr(OFF_THR_LO, 8'h11);
		rchk(OFF_THR_LO, 8'h11, "thr lo");
		chk(16'(lvl), 16'h0001, "forced level");
		u_host.wr(OFF_CTRL, 8'h01);
		exp_q.delete();
		rchk(OFF_CNT_LO, 8'h00, "count flushed");
		rchk(OFF_FIFO, 8'h05, "empty read");
		rchk(OFF_CNT_LO, 8'h00, "count empty");
		push(4);
		vertical_envelope = 1'b0;
		@(negedge clk);
		vertical_envelope = 1'b1;
		exp_q.delete();
		settle();
		chk(16'(st[5:2]), 16'h000d, "eof sof fifo_error_flag");
		rchk(OFF_CNT_LO, 8'h00, "count at frame");
		mci = 1'b1;
		@(negedge clk);
		mci = 1'b0;
		u_host.wr(OFF_ACK, 8'h34);
		settle();
		chk(16'(st[5:2]), 16'h0002, "partial ack");
		u_host.wr(OFF_MASK, 8'h08);
		rchk(OFF_MASK, 8'h08, "mask");
		chk(16'(irq), 16'h0001, "irq high");
		u_host.wr(OFF_CTRL, 8'h20);
		settle();
		chk(16'(irq), 16'h0000, "irq low active");
		u_host.wr(OFF_ACK, 8'h08);
		settle();
		chk(16'(irq), 16'h0001, "irq acked");
		u_host.wr(OFF_MASK, 8'h00);
		push(2049);
		exp_q.delete();
		settle();
		chk(16'(st[ST_FIFO_ERROR_FLAG]), 16'h0001, "overflow");
		rchk(OFF_CNT_HI, 8'h08, "full count");
		u_host.wr(OFF_CTRL, 8'h01);
		u_host.wr(OFF_THR_LO, 8'h20);
		dma_on = 1'b1;
		for (int bs = 1; bs < 4; bs++)
		begin
			len = 6'h04 << bs;
			pol = bs[0];
			slow = bs[1];
			u_host.wr(OFF_CTRL, {3'h0, pol, bs[1:0], 2'h0});
			u_host.got.delete();
			push(32);
			wait_dma(int'(len));
			chk(16'(u_host.got.size()), 16'(len), "burst size");
			while (u_host.got.size() > 0)
				chk(16'(u_host.got.pop_front()), 16'(exp_q.pop_front()), "dma");
			rchk(OFF_CNT_LO, 8'h20 - 8'(len), "count after");
			u_host.wr(OFF_CTRL, 8'h01);
			exp_q.delete();
			settle();
			chk(16'(oe), 16'h0000, "drq released");
		end
		// Short tail at frame end: threshold drops to one, the burst is
		// padded with replays of the last byte, and its end marks image done
		dma_on = 1'b0;
		len = 6'h08;
		pol = 1'b0;
		u_host.wr(OFF_CTRL, 8'h04);
		push(3);
		vertical_envelope = 1'b0;
		settle();
		chk(16'(lvl), 16'h0001, "tail level");
		u_host.wr(OFF_ACK, 8'h20);
		settle();
		chk(16'(st[ST_EOF]), 16'h0000, "eof acked");
		u_host.got.delete();
		dma_on = 1'b1;
		wait_dma(8);
		chk(16'(u_host.got.size()), 16'h0008, "pad count");
		repeat (8)
		begin
			if (exp_q.size() > 0)
				pad = exp_q.pop_front();
			chk(16'(u_host.got.pop_front()), 16'(pad), "pad byte");
		end
		chk(16'(st[ST_EOF]), 16'h0001, "image done");
		report_and_stop();
	end
endmodule : ifhdp_bench
`default_nettype wire

// file: testbench/ifhdp_host.sv
// Host processor and DMA controller model on the register strobes.
// Assumes the bench calls wr/rd only while the DMA side is idle.
`timescale 1ns/1ps
`default_nettype none
module ifhdp_host
	import ifhdp_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic dma_on_i, // Serve requests
	input wire logic slow_i, // Gaps in burst
	input wire logic pol_i, // Drq active low
	input wire logic [5:0] len_i, // Burst bytes
	input wire logic drq_i, // Drq pin
	input wire logic drq_oe_i, // Drq driven
	input wire logic [7:0] rdata_i, // Rdata
	output logic wr_o, // Write
	output logic rd_o, // Read
	output logic [2:0] addr_o, // Offset
	output logic [7:0] wdata_o // Wdata
);
	logic [7:0] got [$];
	logic [7:0] b;
	logic act_q = 1'b0;
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 3'h0;
		wdata_o = 8'h00;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		// Base decode sits outside the block; only the offset arrives
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask : rd
	// Level sensitive in effect: act_q never sets, so a request still held after a burst is served again
	always
	begin
		@(negedge clk_i);
		if (dma_on_i && drq_oe_i && (drq_i ^ pol_i) && !act_q)
		begin
			for (int k = 0; k < int'(len_i); k++)
			begin
				rd(OFF_FIFO, b);
				got.push_back(b);
				if (slow_i)
					repeat (2) @(negedge clk_i);
			end
			// The request drops during a burst, so a level seen now is new
			act_q = 1'b0;
		end
		else
		begin
			// A halted controller tracks no edge; enabling it sees the level
			act_q = dma_on_i && drq_oe_i && (drq_i ^ pol_i);
		end
	end
endmodule : ifhdp_host
`default_nettype wire

// file: testbench/ifhdp_monitor.sv
// Port checker for the image FIFO host port, bound below.
// Assumes registers change only through the indirect write strobe.
`timescale 1ns/1ps
`default_nettype none
module ifhdp_monitor
	import ifhdp_pkg::*;
(
	input wire logic core_clk_i, // Clock
	input wire logic srst_i, // Reset
	input wire logic reg_wr_i, // Write
	input wire logic reg_rd_i, // Read
	input wire logic [2:0] reg_addr_i, // Offset
	input wire logic [7:0] reg_wdata_i, // Wdata
	input wire logic [7:0] reg_rdata_o, // Rdata
	input wire logic img_valid_i, // Byte strobe
	input wire logic [7:0] img_data_i, // Byte
	input wire logic vertical_envelope_i, // Frame
	input wire logic mci_event_i, // Event
	input wire logic [7:0] host_status_byte_o, // Status
	input wire logic fifo_level_reached_o, // Level
	input wire logic irq_pin_o, // Irq pin
	input wire logic dma_request_pin_o, // Drq pin
	input wire logic dma_request_pin_oe_o // Drq enable
);
	logic [7:0] ctrl_q;
	logic [7:0] mask_q;
	logic [5:0] mask_p_q;
	logic act;
	logic hit;
	assign act = dma_request_pin_oe_o && (dma_request_pin_o ^ ctrl_q[4]);
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			ctrl_q <= 8'h00;
			mask_q <= 8'h00;
		end
		else if (reg_wr_i && reg_addr_i == OFF_CTRL)
			ctrl_q <= reg_wdata_i & 8'h3c;
		else if (reg_wr_i && reg_addr_i == OFF_MASK)
			mask_q <= reg_wdata_i & 8'h3f;
	end
	// Status and its interrupt bit are built from the mask one cycle older
	always_ff @(posedge core_clk_i)
	begin
		mask_p_q <= srst_i ? 6'h00 : mask_q[5:0];
	end
	assign hit = |(host_status_byte_o[5:0] & mask_p_q);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	oe_follow_a: assert property ($stable(ctrl_q) |->
		dma_request_pin_oe_o == (ctrl_q[3:2] != 2'h0)) else $error("drq enable");
	ready_bit_a: assert property (host_status_byte_o[ST_RDY] &&
		!host_status_byte_o[6]) else $error("status ready");
	irq_low_a: assert property (!hit |-> !host_status_byte_o[ST_IRQ])
		else $error("irq set");
	irq_high_a: assert property (hit |-> host_status_byte_o[ST_IRQ])
		else $error("irq clear");
	irq_pin_a: assert property ($stable(ctrl_q) |->
		irq_pin_o == (host_status_byte_o[ST_IRQ] ^ ctrl_q[5])) else $error("irq pin");
	drq_drop_a: assert property (act && reg_rd_i && reg_addr_i == OFF_FIFO
		&& $stable(ctrl_q) |=> !act) else $error("drq held");
	rdata_hold_a: assert property (!$past(reg_rd_i) |->
		$stable(reg_rdata_o)) else $error("rdata moved");
	ctrl_read_a: assert property (reg_rd_i && reg_addr_i == OFF_CTRL |=>
		reg_rdata_o == ctrl_q) else $error("ctrl read");
	sof_set_a: assert property ($rose(vertical_envelope_i) |-> ##[1:2]
		host_status_byte_o[ST_SOF]) else $error("sof");
	cover property (act && reg_rd_i);
	cover property ($rose(host_status_byte_o[ST_FIFO_ERROR_FLAG]));
	cover property ($rose(irq_pin_o));
endmodule : ifhdp_monitor
bind ifhdp_top ifhdp_monitor u_mon (.core_clk_i, .srst_i, .reg_wr_i, .reg_rd_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .img_valid_i, .img_data_i,
	.vertical_envelope_i, .mci_event_i, .host_status_byte_o,
	.fifo_level_reached_o, .irq_pin_o, .dma_request_pin_o,
	.dma_request_pin_oe_o);
`default_nettype wire
